// ==== rtl/rss_supervisor.sv ====
// rss_supervisor: reset sources, reset pulse, temperature and supply watch
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_supervisor #(
  parameter int unsigned RST_LEN0_CYC =
    `RSS_TW_RST0_US * (`RSS_CLK_KHZ / 1000),
  parameter int unsigned RST_LEN1_CYC =
    `RSS_TW_RST1_US * (`RSS_CLK_KHZ / 1000),
  parameter int unsigned RST_LEN2_CYC =
    `RSS_TW_RST2_US * (`RSS_CLK_KHZ / 1000),
  parameter int unsigned RST_LEN3_CYC =
    `RSS_TW_RST3_US * (`RSS_CLK_KHZ / 1000),
  parameter int unsigned IN_RST_MIN_CYC = `RSS_IN_RST_MIN_CYC,
  parameter int unsigned STARTUP_CYC    = `RSS_STARTUP_CYC,
  parameter bit          HAS_SENSOR     = 1'b1
) (
  // clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // open-drain reset pin toward the microcontroller
  input  wire logic       system_reset_pin_n_i,
  output logic            system_reset_pin_n_o,
  output logic            system_reset_pin_n_oe_o,
  // analog comparators, asynchronous
  input  wire logic       battery_supply_poff_i,
  input  wire logic       battery_supply_pon_i,
  input  wire logic       battery_supply_below_2v_i,
  input  wire logic [3:0] main_supply_below_i,
  input  wire logic       temp_over_act_i,
  input  wire logic       temp_below_rel_i,
  input  wire logic       temp_over_warn_i,
  input  wire logic       sensor_supply_uv_i,
  input  wire logic       sensor_supply_ov_i,
  // watchdog, mode control and wake logic, same clock
  input  wire logic       wd_overflow_window_i,
  input  wire logic       wd_trigger_early_i,
  input  wire logic       wd_overflow_timeout_i,
  input  wire logic       watchdog_fail_pending_i,
  input  wire logic       wd_ctrl_write_normal_i,
  input  wire logic       illegal_sleep_cmd_i,
  input  wire logic       wake_in_sleep_i,
  input  wire logic       mode_normal_i,
  input  wire logic       mode_sleep_i,
  input  wire logic [1:0] main_threshold_startup_i,
  // supply and state outputs
  output logic            main_supply_output_en_o,
  output logic            sensor_supply_output_en_o,
  output logic            can_off_o,
  output logic            reset_done_o,
  output logic      [1:0] supervisor_state_o
);

  localparam int CW = `RSS_CNT_W;
  localparam int FW = `RSS_FLT_W;

  // refuse zero reset-1..3 and startup counts, short filter counts, and reset-0, startup and filter counts that the counters cannot hold
  if (RST_LEN0_CYC >= (1 << CW) || RST_LEN3_CYC < 1 ||
      RST_LEN1_CYC < 1 || RST_LEN2_CYC < 1 ||
      IN_RST_MIN_CYC < 4 || IN_RST_MIN_CYC >= (1 << FW) ||
      STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CW)) begin : g_chk
    $error("rss_supervisor: count parameter out of range");
  end

  localparam logic [CW-1:0] LEN0_LAST = CW'(RST_LEN0_CYC - 1);
  localparam logic [CW-1:0] LEN1_LAST = CW'(RST_LEN1_CYC - 1);
  localparam logic [CW-1:0] LEN2_LAST = CW'(RST_LEN2_CYC - 1);
  localparam logic [CW-1:0] LEN3_LAST = CW'(RST_LEN3_CYC - 1);
  localparam logic [CW-1:0] SU_LAST   = CW'(STARTUP_CYC - 1);
  localparam logic [FW-1:0] FLT_LAST  = FW'(IN_RST_MIN_CYC - 1);

  rss_pkg::rss_regs_s q;
  rss_pkg::rss_regs_s d;

  logic [`RSS_NSYNC-1:0] async_in;
  logic                  pin_s;
  logic                  poff_s;
  logic                  pon_s;
  logic                  below2v_s;
  logic [3:0]            uv_s;
  logic                  t_act_s;
  logic                  t_rel_s;
  logic                  t_warn_s;
  logic                  sen_uv_s;
  logic                  sen_ov_s;
  logic                  uv_sel;
  logic                  ext_rst;
  logic                  src_any;
  logic [CW-1:0]         len_last;
  logic [1:0]            sen_stat;
  logic [7:0]            evt_vec;

  // pins gathered for the two-stage synchroniser
  assign async_in = {system_reset_pin_n_i, battery_supply_poff_i,
                     battery_supply_pon_i, battery_supply_below_2v_i,
                     main_supply_below_i, temp_over_act_i,
                     temp_below_rel_i, temp_over_warn_i,
                     sensor_supply_uv_i, sensor_supply_ov_i};

  // only the second stage is ever looked at
  assign {pin_s, poff_s, pon_s, below2v_s, uv_s, t_act_s, t_rel_s,
          t_warn_s, sen_uv_s, sen_ov_s} = q.sync2;

  // bit 0 of uv_s is the 90 percent comparator, bit 3 the 60 percent one
  assign uv_sel = uv_s[q.main_threshold_sel];

  // outside low counted only while we release the pin and after the guard
  assign ext_rst = (q.low_cnt == FLT_LAST) && !pin_s;

  // every request that sends run into reset
  assign src_any = ext_rst
                 | wd_overflow_window_i | wd_trigger_early_i
                 | (wd_overflow_timeout_i & watchdog_fail_pending_i)
                 | wd_ctrl_write_normal_i
                 | illegal_sleep_cmd_i
                 | (wake_in_sleep_i & mode_sleep_i)
                 | uv_sel;

  // cold starts honour the length field, warm starts take the shortest
  always_comb begin
    if (!q.cold) begin
      len_last = LEN3_LAST;
    end else begin
      unique case (q.reset_length_sel)
        2'h0: len_last = LEN0_LAST;
        2'h1: len_last = LEN1_LAST;
        2'h2: len_last = LEN2_LAST;
        2'h3: len_last = LEN3_LAST;
      endcase
    end
  end

  // sensor status, fixed at ok on parts without the sensor supply
  always_comb begin
    if (!HAS_SENSOR) begin
      sen_stat = 2'h0;
    end else if (!q.sensor_en) begin
      sen_stat = 2'h3;
    end else if (sen_ov_s) begin
      sen_stat = 2'h2;
    end else if (sen_uv_s) begin
      sen_stat = 2'h1;
    end else begin
      sen_stat = 2'h0;
    end
  end

  assign evt_vec = {4'h0, t_warn_s, q.main_undervolt_event,
                    q.overtemp_warn_event, q.power_on_event};

  // next-state of the whole block
  always_comb begin
    d            = q;
    d.sync1      = async_in;
    d.sync2      = q.sync1;
    d.warn_prev  = t_warn_s;
    d.uv90_prev  = uv_s[0];
    d.rdata      = 8'h00;
    d.reset_done = 1'b0;

    // input-width filter; our own drive and its echo are never counted
    if (q.pin_oe || q.guard != 3'h0 || pin_s) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != FLT_LAST) begin
      d.low_cnt = q.low_cnt + FW'(1);
    end
    if (q.pin_oe) begin
      d.guard = `RSS_SENSE_GUARD;
    end else if (q.guard != 3'h0) begin
      d.guard = q.guard - 3'h1;
    end

    // sticky events; a set in the same cycle as its clear wins
    if (reg_wr_i && reg_addr_i == `RSS_ADDR_EVENT) begin
      if (reg_wdata_i[`RSS_EVT_PO_BIT])  d.power_on_event       = 1'b0;
      if (reg_wdata_i[`RSS_EVT_OTW_BIT]) d.overtemp_warn_event  = 1'b0;
      if (reg_wdata_i[`RSS_EVT_UV_BIT])  d.main_undervolt_event = 1'b0;
    end
    // temperature not watched in sleep or off
    if (t_warn_s && !q.warn_prev && q.state != rss_pkg::RSS_OFF &&
        !(q.state == rss_pkg::RSS_RUN && mode_sleep_i)) begin
      d.overtemp_warn_event = 1'b1;
    end
    if (uv_s[0] && !q.uv90_prev && q.main_undervolt_event_en) begin
      d.main_undervolt_event = 1'b1;
    end

    // register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RSS_ADDR_SUPPLY_CTRL: begin
          d.aux_supply_config  = reg_wdata_i[`RSS_AUX_LSB +: 2];
          d.main_threshold_sel = reg_wdata_i[`RSS_THR_LSB +: 2];
        end
        `RSS_ADDR_STARTUP_CTRL: begin
          d.reset_length_sel       = reg_wdata_i[`RSS_RLC_LSB +: 2];
          d.aux_supply_startup_sel = reg_wdata_i[`RSS_AUXSU_BIT];
        end
        `RSS_ADDR_EVENT_EN: d.main_undervolt_event_en = reg_wdata_i[0];
        default: ;
      endcase
    end

    // register reads, data valid in the next cycle only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RSS_ADDR_SUPPLY_CTRL: d.rdata = {4'h0, q.aux_supply_config,
                                          q.main_threshold_sel};
        `RSS_ADDR_SUPPLY_STAT: d.rdata = {5'h00, sen_stat,
                                          uv_s[0]};
        `RSS_ADDR_STARTUP_CTRL: d.rdata = {2'h0, q.reset_length_sel,
                                           q.aux_supply_startup_sel,
                                           3'h0};
        `RSS_ADDR_EVENT:    d.rdata = evt_vec;
        `RSS_ADDR_EVENT_EN: d.rdata = {7'h00, q.main_undervolt_event_en};
        `RSS_ADDR_STATE:    d.rdata = {6'h00, q.state};
        default:            d.rdata = 8'h00;
      endcase
    end

    // supervisor state machine
    unique case (q.state)
      rss_pkg::RSS_OFF: begin
        if (pon_s && !poff_s) begin
          d.cnt = q.cnt + CW'(1);
          if (q.cnt == SU_LAST) begin
            d.state          = rss_pkg::RSS_RESET;
            d.cnt            = '0;
            d.cold           = 1'b1;
            d.power_on_event = 1'b1;
            // power-up presets taken as the device leaves off
            d.aux_supply_config = q.aux_supply_startup_sel ?
                                  2'h3 : 2'h0;
            d.main_threshold_sel = main_threshold_startup_i;
          end
        end else begin
          d.cnt = '0;
        end
      end
      rss_pkg::RSS_RESET: begin
        if (t_act_s) begin
          d.state = rss_pkg::RSS_OTEMP;
        end else if (uv_sel) begin
          // undervoltage holds the pulse and makes it a cold start
          d.cold = 1'b1;
          d.cnt  = '0;
        end else if (q.cnt == len_last) begin
          d.state      = rss_pkg::RSS_RUN;
          d.cnt        = '0;
          d.cold       = 1'b0;
          d.reset_done = 1'b1;
        end else begin
          d.cnt = q.cnt + CW'(1);
        end
      end
      rss_pkg::RSS_OTEMP: begin
        if (t_rel_s && !t_act_s) begin
          d.state = rss_pkg::RSS_RESET;
          d.cnt   = '0;
          d.cold  = 1'b1;
        end
      end
      rss_pkg::RSS_RUN: begin
        if (t_act_s && !mode_sleep_i) begin
          d.state = rss_pkg::RSS_OTEMP;
        end else if (src_any) begin
          d.state = rss_pkg::RSS_RESET;
          d.cnt   = '0;
          d.cold  = uv_sel | mode_sleep_i;
        end
      end
    endcase

    // battery loss overrides every other state
    if (poff_s && q.state != rss_pkg::RSS_OFF) begin
      d.state = rss_pkg::RSS_OFF;
      d.cnt   = '0;
    end

    // pin drive: one low pulse for as long as the device is not running
    d.pin_oe = (q.state != rss_pkg::RSS_RUN);

    // main supply: kept in off down to 2 V, dropped in overtemp and sleep
    unique case (q.state)
      rss_pkg::RSS_OFF:   d.main_en = !below2v_s;
      rss_pkg::RSS_OTEMP: d.main_en = 1'b0;
      rss_pkg::RSS_RUN:   d.main_en = !mode_sleep_i;
      rss_pkg::RSS_RESET: d.main_en = 1'b1;
    endcase

    // sensor supply by configuration and mode
    unique case (q.state)
      rss_pkg::RSS_RUN: begin
        if (mode_normal_i) begin
          d.sensor_en = (q.aux_supply_config != 2'h0);
        end else if (mode_sleep_i) begin
          d.sensor_en = (q.aux_supply_config == 2'h3);
        end else begin
          d.sensor_en = q.aux_supply_config[1];
        end
      end
      rss_pkg::RSS_RESET: d.sensor_en = q.aux_supply_config[1];
      default:            d.sensor_en = 1'b0;
    endcase

    d.can_off = (q.state == rss_pkg::RSS_OTEMP) ||
                (q.state == rss_pkg::RSS_OFF);
  end

  // state register: synchronous reset, frozen while the enable is low
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      q.sync1                   <= '1;
      q.sync2                   <= '1;
      // match the all-ones synchroniser reset, so no false edge follows
      q.warn_prev               <= 1'b1;
      q.uv90_prev               <= 1'b1;
      q.state                   <= rss_pkg::RSS_OFF;
      q.cnt                     <= '0;
      q.low_cnt                 <= '0;
      q.guard                   <= `RSS_SENSE_GUARD;
      q.cold                    <= 1'b1;
      q.reset_length_sel        <= `RSS_RLC_RST;
      q.aux_supply_startup_sel  <= `RSS_AUXSU_RST;
      q.aux_supply_config       <= `RSS_AUX_RST;
      q.main_threshold_sel      <= `RSS_THR_RST;
      q.main_undervolt_event_en <= 1'b0;
      q.power_on_event          <= 1'b0;
      q.overtemp_warn_event     <= 1'b0;
      q.main_undervolt_event    <= 1'b0;
      q.rdata                   <= 8'h00;
      q.pin_oe                  <= 1'b1;
      q.main_en                 <= 1'b0;
      q.sensor_en               <= 1'b0;
      q.can_off                 <= 1'b1;
      q.reset_done              <= 1'b0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  // outputs straight from the state record; the pin only ever pulls low
  assign reg_rdata_o               = q.rdata;
  assign system_reset_pin_n_o      = 1'b0;
  assign system_reset_pin_n_oe_o   = q.pin_oe;
  assign main_supply_output_en_o   = q.main_en;
  assign sensor_supply_output_en_o = q.sensor_en;
  assign can_off_o                 = q.can_off;
  assign reset_done_o              = q.reset_done;
  assign supervisor_state_o        = q.state;

endmodule : rss_supervisor

// ==== common/rss_cfg.svh ====
// rss_cfg.svh: offsets, field positions, reset values and timing counts
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// clock rate
`define RSS_CLK_KHZ           250000
// register byte offsets
`define RSS_ADDR_SUPPLY_CTRL  8'h10
`define RSS_ADDR_SUPPLY_STAT  8'h1B
`define RSS_ADDR_STARTUP_CTRL 8'h73
`define RSS_ADDR_EVENT        8'h60
`define RSS_ADDR_EVENT_EN     8'h61
`define RSS_ADDR_STATE        8'h62
// field positions
`define RSS_THR_LSB           0
`define RSS_AUX_LSB           2
`define RSS_AUXSU_BIT         3
`define RSS_RLC_LSB           4
`define RSS_EVT_PO_BIT        0
`define RSS_EVT_OTW_BIT       1
`define RSS_EVT_UV_BIT        2
`define RSS_EVT_OVERTEMP_WARN_STATUS_BIT      3
// reset values
`define RSS_RLC_RST           2'h0
`define RSS_AUXSU_RST         1'h0
`define RSS_THR_RST           2'h0
`define RSS_AUX_RST           2'h0
// output reset pulse, least width per code, in microseconds
`define RSS_TW_RST0_US        20000
`define RSS_TW_RST1_US        10000
`define RSS_TW_RST2_US        3600
`define RSS_TW_RST3_US        1000
// plain defaults for widths the analog side does not fix
`define RSS_IN_RST_MIN_CYC    16
`define RSS_STARTUP_CYC       16
`define RSS_SENSE_GUARD       3'h3
// widths
`define RSS_CNT_W             24
`define RSS_FLT_W             16
`define RSS_NSYNC             13

`endif

// ==== common/rss_pkg.sv ====
// rss_pkg: state type and state record of the reset and supply supervisor
`include "rss_cfg.svh"
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_OFF   = 2'b00,
    RSS_RESET = 2'b01,
    RSS_OTEMP = 2'b10,
    RSS_RUN   = 2'b11
  } rss_state_e;

  typedef struct packed {
    logic [`RSS_NSYNC-1:0] sync1;
    logic [`RSS_NSYNC-1:0] sync2;
    logic                  warn_prev;
    logic                  uv90_prev;
    rss_state_e            state;
    logic [`RSS_CNT_W-1:0] cnt;
    logic [`RSS_FLT_W-1:0] low_cnt;
    logic [2:0]            guard;
    logic                  cold;
    logic [1:0]            reset_length_sel;
    logic                  aux_supply_startup_sel;
    logic [1:0]            aux_supply_config;
    logic [1:0]            main_threshold_sel;
    logic                  main_undervolt_event_en;
    logic                  power_on_event;
    logic                  overtemp_warn_event;
    logic                  main_undervolt_event;
    logic [7:0]            rdata;
    logic                  pin_oe;
    logic                  main_en;
    logic                  sensor_en;
    logic                  can_off;
    logic                  reset_done;
  } rss_regs_s;

endpackage : rss_pkg

// ==== dv/rss_sup_checker_assertions.sv ====
// rss_sup_checker: port-level properties of the reset supervisor
`timescale 1ns/1ps
module rss_sup_checker #(
  parameter int unsigned RST_LEN3_CYC = 250000
) (
  // clock, reset and enable
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic       clk_en_i,
  // reset pin drive
  input wire logic       system_reset_pin_n_o,
  input wire logic       system_reset_pin_n_oe_o,
  // reset sources
  input wire logic       wd_overflow_window_i,
  input wire logic       wd_trigger_early_i,
  input wire logic       wd_overflow_timeout_i,
  input wire logic       watchdog_fail_pending_i,
  input wire logic       wd_ctrl_write_normal_i,
  input wire logic       illegal_sleep_cmd_i,
  input wire logic       wake_in_sleep_i,
  input wire logic       mode_sleep_i,
  // supplies and state
  input wire logic       main_supply_output_en_o,
  input wire logic       can_off_o,
  input wire logic       reset_done_o,
  input wire logic [1:0] supervisor_state_o
);
  logic [31:0] in_rst_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  // the supervisor does not advance while the enable is low, so nothing is judged then
  default disable iff (!nrst_i || !clk_en_i);

  // cycles spent in reset; a counter, as the pulse is too long to unroll
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || supervisor_state_o != 2'b01) in_rst_q <= 32'h0;
    else in_rst_q <= in_rst_q + 32'h1;
  end

  // pin drive, pulse shape, reset entry and supplies in overtemperature
  a_sink_only:
    assert property (system_reset_pin_n_o == 1'b0)
    else $error("reset pin driven high");
  a_drive_outside_run:
    assert property (supervisor_state_o != 2'b11 &&
      $past(supervisor_state_o) != 2'b11 |-> system_reset_pin_n_oe_o)
    else $error("reset pin released outside run");
  a_release_in_run:
    assert property (supervisor_state_o == 2'b11 &&
      $past(supervisor_state_o) == 2'b11 |-> !system_reset_pin_n_oe_o)
    else $error("reset pin held in run");
  a_done_single:
    assert property (reset_done_o |=>
      !reset_done_o && supervisor_state_o == 2'b11)
    else $error("reset done not a single pulse into run");
  a_pulse_min_len:
    assert property ($fell(supervisor_state_o == 2'b01) &&
      supervisor_state_o == 2'b11 |-> in_rst_q >= RST_LEN3_CYC)
    else $error("reset pulse shorter than warm length");
  a_wd_reset:
    assert property ((wd_overflow_window_i || wd_trigger_early_i ||
      (wd_overflow_timeout_i && watchdog_fail_pending_i)) &&
      supervisor_state_o == 2'b11 |=> supervisor_state_o == 2'b01)
    else $error("watchdog fault without reset");
  a_cmd_reset:
    assert property ((wd_ctrl_write_normal_i || illegal_sleep_cmd_i ||
      (wake_in_sleep_i && mode_sleep_i)) &&
      supervisor_state_o == 2'b11 |=> supervisor_state_o == 2'b01)
    else $error("command or wake without reset");
  a_otemp_off:
    assert property (supervisor_state_o == 2'b10 [*2] |->
      !main_supply_output_en_o && can_off_o)
    else $error("supplies left on in overtemperature");
endmodule : rss_sup_checker

bind rss_supervisor rss_sup_checker #(
  .RST_LEN3_CYC(RST_LEN3_CYC)
) i_rss_sup_checker (
  .sys_clk_i, .nrst_i, .clk_en_i, .system_reset_pin_n_o,
  .system_reset_pin_n_oe_o,
  .wd_overflow_window_i, .wd_trigger_early_i, .wd_overflow_timeout_i,
  .watchdog_fail_pending_i, .wd_ctrl_write_normal_i, .illegal_sleep_cmd_i,
  .wake_in_sleep_i, .mode_sleep_i, .main_supply_output_en_o, .can_off_o,
  .reset_done_o, .supervisor_state_o
);

// ==== dv/rss_host_model.sv ====
// rss_host_model: host side of the shared open-drain reset wire
`timescale 1ns/1ps
module rss_host_model (
  // clock
  input  wire logic       sys_clk_i,
  // pull request from the bench
  input  wire logic [7:0] pull_len_i,
  input  wire logic       pull_go_i,
  // device side of the wire
  input  wire logic       dev_oe_i,
  input  wire logic       dev_lvl_i,
  output logic            wire_n_o
);
  logic [7:0] left_q = 8'h00;

  // host sinks the wire for the requested number of cycles
  always_ff @(posedge sys_clk_i) begin
    if (pull_go_i) left_q <= pull_len_i;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end

  // pull-up wins unless a party sinks the wire
  assign wire_n_o = !((dev_oe_i && !dev_lvl_i) || left_q != 8'h00);
endmodule : rss_host_model

// ==== dv/rss_supervisor_tb.sv ====
// rss_supervisor_tb: register-level test of the reset supervisor
`timescale 1ns/1ps
module rss_supervisor_tb;
  localparam int unsigned L0 = 40, L1 = 20, L2 = 10, L3 = 5;
  logic        clk, nrst, wr, rd, poff, pon, t_act, t_rel, t_warn;
  logic        s_uv, fail, m_sleep, pu_go, pin_n, pin_o, pin_oe;
  logic        main_en, sens_en, can_off, done, cen, m_norm, b2v;
  logic [1:0]  state;
  logic [3:0]  below;
  logic [5:0]  src;
  logic [7:0]  addr, wdata, pu_len, rdata;
  int          failures = 0, comparisons = 0, k;
  int unsigned lens [4] = '{L0, L1, L2, L3};

  rss_supervisor #(
    .RST_LEN0_CYC(L0), .RST_LEN1_CYC(L1), .RST_LEN2_CYC(L2),
    .RST_LEN3_CYC(L3)
  ) i_rss_supervisor (
    .sys_clk_i(clk), .nrst_i(nrst), .clk_en_i(cen),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata),
    .system_reset_pin_n_i(pin_n), .system_reset_pin_n_o(pin_o),
    .system_reset_pin_n_oe_o(pin_oe),
    .battery_supply_poff_i(poff), .battery_supply_pon_i(pon),
    .battery_supply_below_2v_i(b2v), .main_supply_below_i(below),
    .temp_over_act_i(t_act), .temp_below_rel_i(t_rel),
    .temp_over_warn_i(t_warn), .sensor_supply_uv_i(s_uv),
    .sensor_supply_ov_i(1'b0), .wd_overflow_window_i(src[0]),
    .wd_trigger_early_i(src[1]), .wd_overflow_timeout_i(src[2]),
    .watchdog_fail_pending_i(fail), .wd_ctrl_write_normal_i(src[3]),
    .illegal_sleep_cmd_i(src[4]), .wake_in_sleep_i(src[5]),
    .mode_normal_i(m_norm), .mode_sleep_i(m_sleep),
    .main_threshold_startup_i(2'h2), .main_supply_output_en_o(main_en),
    .sensor_supply_output_en_o(sens_en), .can_off_o(can_off),
    .reset_done_o(done), .supervisor_state_o(state)
  );

  rss_host_model i_rss_host_model (
    .sys_clk_i(clk), .pull_len_i(pu_len), .pull_go_i(pu_go),
    .dev_oe_i(pin_oe), .dev_lvl_i(pin_o), .wire_n_o(pin_n)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(nm, e, rdata);
  endtask : rd_chk

  // bounded wait; a hang ends the run at once
  task automatic wait_st(input logic [1:0] s);
    for (int i = 0; i < 400 && state !== s; i++) @(posedge clk) #1;
    check("state", {6'h0, s}, {6'h0, state});
    if (state !== s) complete_run();
  endtask : wait_st

  // time spent in reset, with slack for sync and register stages
  task automatic cnt_rst(input int unsigned l);
    int unsigned c;
    c = 1;
    wait_st(2'h1);
    while (state === 2'h1 && c < 400) @(posedge clk) #1 c++;
    check("reset length", 8'h01, {7'h0, c >= l && c <= l + 3});
  endtask : cnt_rst

  task automatic pulse(input int b);
    @(posedge clk);
    src <= 6'h01 << b;
    @(posedge clk);
    src <= 6'h00;
  endtask : pulse

  task automatic host_pull(input logic [7:0] l);
    @(posedge clk);
    pu_len <= l;
    pu_go <= 1'b1;
    @(posedge clk);
    pu_go <= 1'b0;
  endtask : host_pull

  initial begin
    {nrst, wr, rd, poff, t_act, t_warn, s_uv, fail, m_sleep, pu_go} = '0;
    {pon, t_rel} = 2'h3;
    {cen, m_norm, b2v} = 3'h4;
    {addr, wdata, pu_len, below, src} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // power-up is a cold start with the reset-value length code
    cnt_rst(L0);
    wait_st(2'h3);
    rd_chk("events", 8'h60, 8'h01);
    rd_chk("supply ctrl", 8'h10, 8'h02);
    rd_chk("supply status", 8'h1B, 8'h06);
    rd_chk("unmapped", 8'h55, 8'h00);
    // every aux code while in standby
    for (k = 0; k < 4; k++) begin
      wr_reg(8'h10, 8'(k * 4 + 2));
      repeat (3) @(posedge clk);
      #1 check("sensor en", {7'h0, k > 1}, {7'h0, sens_en});
    end
    // code 01 powers the sensor supply in normal mode only
    m_norm <= 1'b1;
    wr_reg(8'h10, 8'h06);
    repeat (3) @(posedge clk);
    #1 check("sensor en", 8'h01, {7'h0, sens_en});
    m_norm <= 1'b0;
    wr_reg(8'h10, 8'h0E);
    // a frozen block ignores a reset request
    @(posedge clk);
    cen <= 1'b0;
    pulse(0);
    repeat (3) @(posedge clk);
    cen <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("frozen state", 8'h03, {6'h0, state});
    s_uv <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk("supply status", 8'h1B, 8'h02);
    s_uv <= 1'b0;
    // warm sources; timeout overflow only with a failure pending
    for (k = 0; k < 5; k++) begin
      fail <= (k == 2);
      pulse(k);
      cnt_rst(L3);
      wait_st(2'h3);
      repeat (2) @(posedge clk);
    end
    fail <= 1'b0;
    pulse(2);
    repeat (6) @(posedge clk);
    #1 check("state", 8'h03, {6'h0, state});
    // wake from sleep is cold: each length code
    m_sleep <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr_reg(8'h73, 8'(k * 16));
      pulse(5);
      cnt_rst(lens[k]);
      wait_st(2'h3);
    end
    m_sleep <= 1'b0;
    rd_chk("startup ctrl", 8'h73, 8'h30);
    // under 90 and 80 percent is only a warning at the 70 setting
    wr_reg(8'h61, 8'h01);
    below <= 4'h3;
    repeat (10) @(posedge clk);
    #1 check("state", 8'h03, {6'h0, state});
    rd_chk("supply status", 8'h1B, 8'h01);
    rd_chk("events", 8'h60, 8'h05);
    below <= 4'h7;
    wait_st(2'h1);
    below <= 4'h0;
    wait_st(2'h3);
    wr_reg(8'h60, 8'h07);
    rd_chk("events", 8'h60, 8'h00);
    // overtemperature and its release through reset
    {t_act, t_rel} <= 2'h2;
    wait_st(2'h2);
    repeat (2) @(posedge clk);
    #1 check("otemp", 8'h09, {4'h0, pin_oe, main_en, sens_en, can_off});
    {t_act, t_rel} <= 2'h1;
    wait_st(2'h1);
    wait_st(2'h3);
    t_warn <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk("events", 8'h60, 8'h0A);
    wr_reg(8'h60, 8'h07);
    rd_chk("events", 8'h60, 8'h08);
    t_warn <= 1'b0;
    // host pulls: too short, then long enough
    host_pull(8'h08);
    repeat (30) @(posedge clk);
    #1 check("state", 8'h03, {6'h0, state});
    host_pull(8'h1E);
    wait_st(2'h1);
    wait_st(2'h3);
    // battery cycle reloads the presets
    wr_reg(8'h73, 8'h08);
    wr_reg(8'h10, 8'h00);
    {poff, pon} <= 2'h2;
    wait_st(2'h0);
    repeat (2) @(posedge clk);
    #1 check("main en", 8'h01, {7'h0, main_en});
    b2v <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("main en", 8'h00, {7'h0, main_en});
    b2v <= 1'b0;
    {poff, pon} <= 2'h1;
    cnt_rst(L0);
    wait_st(2'h3);
    rd_chk("supply ctrl", 8'h10, 8'h0E);
    rd_chk("events", 8'h60, 8'h01);
    complete_run();
  end
endmodule : rss_supervisor_tb
